// ---- pkg/dbr_pkg.sv ----
// Package with constants shared by both ends of the two-wire register link.
`default_nettype none
package dbr_pkg;
  localparam logic [6:0] SLAVE_ADDR       = 7'h36;
  localparam logic [7:0] IDX_COMMON       = 8'h00;
  localparam logic [7:0] IDX_RAIL_ONE     = 8'h01;
  localparam logic [7:0] IDX_RAIL_TWO     = 8'h02;
  localparam logic [7:0] MASK_COMMON      = 8'hFF;
  localparam logic [7:0] MASK_RAIL_ONE    = 8'h3F;
  localparam logic [7:0] MASK_RAIL_TWO    = 8'h7F;
  localparam logic [7:0] RESET_VALUE      = 8'h00;
  localparam int         BITS_PER_BYTE    = 8;
  localparam int         CLK_PERIOD_NS    = 100;
  localparam int         SPIKE_NS         = 50;
  localparam int         SPIKE_CYCLES     = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         SCL_MAX_KHZ      = 400;
  localparam int         CLK_MHZ          = 10;
  localparam int         SCL_HALF_CYCLES  = (CLK_MHZ * 1000 + 2 * SCL_MAX_KHZ - 1) / (2 * SCL_MAX_KHZ) + 4;
  localparam logic [3:0] APB_CMD          = 4'h0;
  localparam logic [3:0] APB_STAT         = 4'h4;
  localparam logic [3:0] APB_RDATA        = 4'h8;
  localparam int         CMD_GO_BIT       = 0;
  localparam int         CMD_RD_BIT       = 1;
  localparam int         CMD_IDX_LSB      = 8;
  localparam int         CMD_DATA_LSB     = 16;
  localparam int         STAT_BUSY_BIT    = 0;
  localparam int         STAT_NACK_BIT    = 1;
endpackage
`default_nettype wire

// ---- pkg/dbr_if.sv ----
// Interface carrying the two open-drain bus wires between master and register slave.
`timescale 1ns/1ps
`default_nettype none
interface dbr_if;
  logic sclMasterOe;
  logic sdaMasterOe;
  logic sdaSlaveOe;
  wire  scl = sclMasterOe;
  wire  sda = sdaMasterOe & sdaSlaveOe;
  modport device (input scl, input sda, output sdaSlaveOe);
  modport host (input scl, input sda, output sclMasterOe, output sdaMasterOe);
endinterface
`default_nettype wire

// ---- logic/dbr_slave.sv ----
// Two-wire register slave with three configuration registers.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Data changes only while clock low.
// - Falling data with clock high starts session.
// - Rising data with clock high stops session.
// - Bus busy from start until stop.
// - Master may repeat start mid transfer.
// - Repeated start restarts address reception.
// - Bytes are eight bits, MSB first.
// - Unlimited bytes, each followed by acknowledge.
// - Master clocks every acknowledge pulse.
// - Receiver pulls data low on ninth pulse.
// - Addressed device acknowledges every received byte.
// - First byte: address plus direction bit.
// - Respond only to address 36h.
// - Write: index byte then data byte.
// - Read needs index write then repeated start.
// - Clock up to 400 kHz works.
// - Inputs suppress spikes on both lines.
// - Three read/write registers at 00-02.
// - Rail one bits 6,7 unused.
// - Rail two holds POR disable, bit7 unused.
// - Rail one five-bit voltage code.
// - Rail two five-bit voltage code.
module dbr_slave (
  input  wire logic clk_sys,
  input  wire logic srst,
  dbr_if.device     bus,
  output logic [7:0] commonCfg,
  output logic [7:0] railOneCfg,
  output logic [7:0] railTwoCfg,
  output logic       busBusy
);
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_INDEX, S_WDATA, S_RDATA, S_IGNORE} dbr_sst_t;

  typedef struct packed {
    logic [1:0] sclSync;
    logic [1:0] sdaSync;
    logic [1:0] sclCnt;
    logic [1:0] sdaCnt;
    logic       sclF;
    logic       sdaF;
    dbr_sst_t   st;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic [7:0] index;
    logic [7:0] txByte;
    logic       sdaOe;
    logic       ackPhase;
    logic       busy;
    logic [7:0] regs0;
    logic [7:0] regs1;
    logic [7:0] regs2;
  } dbr_slave_state_t;

  dbr_slave_state_t s_r;
  dbr_slave_state_t s_nxt;

  // Register read mux with unused bits forced to zero.
  function automatic logic [7:0] readReg(input dbr_slave_state_t s, input logic [7:0] idx);
    logic [7:0] v;
    v = 8'h00;
    unique case (idx)
      dbr_pkg::IDX_COMMON:   v = s.regs0 & dbr_pkg::MASK_COMMON;
      dbr_pkg::IDX_RAIL_ONE: v = s.regs1 & dbr_pkg::MASK_RAIL_ONE;
      dbr_pkg::IDX_RAIL_TWO: v = s.regs2 & dbr_pkg::MASK_RAIL_TWO;
      default:               v = 8'h00;
    endcase
    return v;
  endfunction

  // Filters the synchronised lines, detects conditions and walks the byte framing.
  always_comb
  begin
    logic sclRise;
    logic sclFall;
    logic startC;
    logic stopC;
    logic [7:0] full;
    sclRise = 1'b0;
    sclFall = 1'b0;
    startC  = 1'b0;
    stopC   = 1'b0;
    full    = 8'h00;
    s_nxt = s_r;
    s_nxt.sclSync = {s_r.sclSync[0], bus.scl};
    s_nxt.sdaSync = {s_r.sdaSync[0], bus.sda};
    // A line level is accepted only after it persists, which swallows short spikes.
    if (s_r.sclSync[1] == s_r.sclF) s_nxt.sclCnt = 2'd0;
    else if (s_r.sclCnt == 2'(dbr_pkg::SPIKE_CYCLES))
    begin
      s_nxt.sclF = s_r.sclSync[1];
      s_nxt.sclCnt = 2'd0;
    end
    else s_nxt.sclCnt = s_r.sclCnt + 2'd1;
    if (s_r.sdaSync[1] == s_r.sdaF) s_nxt.sdaCnt = 2'd0;
    else if (s_r.sdaCnt == 2'(dbr_pkg::SPIKE_CYCLES))
    begin
      s_nxt.sdaF = s_r.sdaSync[1];
      s_nxt.sdaCnt = 2'd0;
    end
    else s_nxt.sdaCnt = s_r.sdaCnt + 2'd1;
    sclRise = s_nxt.sclF & ~s_r.sclF;
    sclFall = ~s_nxt.sclF & s_r.sclF;
    startC  = s_r.sclF & s_nxt.sclF & s_r.sdaF & ~s_nxt.sdaF;
    stopC   = s_r.sclF & s_nxt.sclF & ~s_r.sdaF & s_nxt.sdaF;
    full    = {s_r.shift[6:0], s_r.sdaF};
    if (startC)
    begin
      // First and repeated starts both restart address reception.
      s_nxt.busy = 1'b1;
      s_nxt.st = S_ADDR;
      s_nxt.bitCnt = 4'd0;
      s_nxt.sdaOe = 1'b1;
      s_nxt.ackPhase = 1'b0;
    end
    else if (stopC)
    begin
      s_nxt.busy = 1'b0;
      s_nxt.st = S_IDLE;
      s_nxt.sdaOe = 1'b1;
    end
    else if (s_r.st != S_IDLE && s_r.st != S_IGNORE)
    begin
      if (sclRise && !s_r.ackPhase)
      begin
        s_nxt.shift = full;
        s_nxt.bitCnt = s_r.bitCnt + 4'd1;
      end
      else if (sclRise && s_r.ackPhase && s_r.st == S_RDATA && s_r.sdaF)
        s_nxt.st = S_IGNORE; // Master declined further read bytes.
      if (sclFall)
      begin
        if (s_r.ackPhase)
        begin
          // Ninth pulse over: release the line or present the next read bit.
          s_nxt.ackPhase = 1'b0;
          s_nxt.bitCnt = 4'd0;
          s_nxt.sdaOe = 1'b1;
          if (s_r.st == S_RDATA)
          begin
            // Load the next read byte and put its first bit out at once; rises count the bits.
            s_nxt.txByte = readReg(s_r, s_r.index);
            s_nxt.sdaOe = s_nxt.txByte[7];
          end
        end
        else if (s_r.st == S_RDATA && s_r.bitCnt != 4'(dbr_pkg::BITS_PER_BYTE))
        begin
          // The bit count was already advanced by the rise, so it names the next bit to show.
          s_nxt.sdaOe = s_r.txByte[3'd7 - s_r.bitCnt[2:0]];
        end
        else if (s_r.bitCnt == 4'(dbr_pkg::BITS_PER_BYTE))
        begin
          s_nxt.ackPhase = 1'b1;
          s_nxt.sdaOe = 1'b1;
          unique case (s_r.st)
            S_ADDR:
            begin
              if (s_r.shift[7:1] == dbr_pkg::SLAVE_ADDR)
              begin
                s_nxt.sdaOe = 1'b0;
                s_nxt.st = s_r.shift[0] ? S_RDATA : S_INDEX;
              end
              else s_nxt.st = S_IGNORE;
            end
            S_INDEX:
            begin
              s_nxt.index = s_r.shift;
              s_nxt.sdaOe = 1'b0;
              s_nxt.st = S_WDATA;
            end
            S_WDATA:
            begin
              s_nxt.sdaOe = 1'b0;
              unique case (s_r.index)
                dbr_pkg::IDX_COMMON:   s_nxt.regs0 = s_r.shift;
                dbr_pkg::IDX_RAIL_ONE: s_nxt.regs1 = s_r.shift & dbr_pkg::MASK_RAIL_ONE;
                dbr_pkg::IDX_RAIL_TWO: s_nxt.regs2 = s_r.shift & dbr_pkg::MASK_RAIL_TWO;
                default:               s_nxt.regs0 = s_r.regs0;
              endcase
              s_nxt.index = s_r.index + 8'h01;
            end
            default: s_nxt.sdaOe = 1'b1;
          endcase
          if (s_r.st == S_RDATA) s_nxt.index = s_r.index + 8'h01;
        end
      end
    end
  end

  // Registers the whole state.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      s_r <= '0;
      s_r.sclSync <= 2'b11;
      s_r.sdaSync <= 2'b11;
      s_r.sclF <= 1'b1;
      s_r.sdaF <= 1'b1;
      s_r.sdaOe <= 1'b1;
      s_r.st <= S_IDLE;
      s_r.regs0 <= dbr_pkg::RESET_VALUE;
      s_r.regs1 <= dbr_pkg::RESET_VALUE;
      s_r.regs2 <= dbr_pkg::RESET_VALUE;
    end
    else s_r <= s_nxt;
  end

  assign bus.sdaSlaveOe = s_r.sdaOe;
  assign commonCfg = s_r.regs0;
  assign railOneCfg = s_r.regs1;
  assign railTwoCfg = s_r.regs2;
  assign busBusy = s_r.busy;
endmodule
`default_nettype wire

// ---- logic/dbr_master.sv ----
// APB-controlled two-wire master that writes or reads one register of the slave.
`timescale 1ns/1ps
`default_nettype none
module dbr_master (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  dbr_if.host              bus,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [3:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  typedef enum logic [2:0] {M_IDLE, M_START, M_BIT, M_STOP, M_DONE} dbr_mst_t;
  typedef struct packed {
    logic [1:0]  sdaSync;
    dbr_mst_t    st;
    logic [7:0]  half;
    logic [1:0]  phase;
    logic [3:0]  bitCnt;
    logic [1:0]  byteNo;
    logic [1:0]  nBytes;
    logic        rd;
    logic        rdPass;
    logic [7:0]  idx;
    logic [7:0]  wdat;
    logic [7:0]  shift;
    logic [7:0]  rdat;
    logic        nack;
    logic        scl;
    logic        sda;
    logic [31:0] prdata;
    logic        pready;
  } dbr_master_state_t;
  dbr_master_state_t m_r;
  dbr_master_state_t m_nxt;

  // Byte sent in slot n of the current pass.
  function automatic logic [7:0] txOf(input dbr_master_state_t m, input logic [1:0] n);
    logic [7:0] v;
    v = m.wdat;
    if (n == 2'd0) v = {dbr_pkg::SLAVE_ADDR, m.rdPass};
    else if (n == 2'd1) v = m.idx;
    return v;
  endfunction

  // APB answers one cycle into the access phase and takes a command only at that edge; the bit clock stays below 400 kHz.
  always_comb
  begin
    logic       tick;
    logic       apbAcc;
    logic [7:0] txb;
    tick = 1'b0;
    apbAcc = psel & penable & ~m_r.pready;
    txb = txOf(m_r, m_r.byteNo);
    m_nxt = m_r;
    m_nxt.sdaSync = {m_r.sdaSync[0], bus.sda};
    m_nxt.pready = apbAcc;
    tick = m_r.half == 8'(dbr_pkg::SCL_HALF_CYCLES);
    m_nxt.half = tick ? 8'h00 : m_r.half + 8'h01;
    if (apbAcc)
    begin
      m_nxt.prdata = 32'h0000_0000;
      if (!pwrite && paddr == dbr_pkg::APB_STAT)
        m_nxt.prdata = {30'h0, m_r.nack, m_r.st != M_IDLE};
      else if (!pwrite && paddr == dbr_pkg::APB_RDATA)
        m_nxt.prdata = {24'h0, m_r.rdat};
    end
    // A command takes effect only at the edge where pready is seen high with the request still standing.
    if (psel && penable && m_r.pready && pwrite && paddr == dbr_pkg::APB_CMD && m_r.st == M_IDLE
        && pwdata[dbr_pkg::CMD_GO_BIT])
    begin
        m_nxt.rd = pwdata[dbr_pkg::CMD_RD_BIT];
        m_nxt.idx = pwdata[dbr_pkg::CMD_IDX_LSB +: 8];
        m_nxt.wdat = pwdata[dbr_pkg::CMD_DATA_LSB +: 8];
        m_nxt.rdPass = 1'b0;
        m_nxt.nack = 1'b0;
        m_nxt.st = M_START;
        m_nxt.phase = 2'd0;
    end
    if (tick)
    begin
      unique case (m_r.st)
        M_START:
        begin
          // Lines high, then data falls under a high clock, then clock falls.
          m_nxt.phase = m_r.phase + 2'd1;
          if (m_r.phase == 2'd0)
          begin
            m_nxt.sda = 1'b1;
            m_nxt.scl = 1'b1;
          end
          else if (m_r.phase == 2'd1) m_nxt.sda = 1'b0;
          else
          begin
            m_nxt.scl = 1'b0;
            m_nxt.st = M_BIT;
            m_nxt.byteNo = 2'd0;
            m_nxt.bitCnt = 4'd0;
            m_nxt.phase = 2'd0;
            m_nxt.nBytes = m_r.rdPass ? 2'd2 : (m_r.rd ? 2'd2 : 2'd3);
          end
        end
        M_BIT:
        begin
          m_nxt.phase = m_r.phase + 2'd1;
          if (m_r.phase == 2'd0)
          begin
            // Data set while clock low; slot 8 is the acknowledge.
            if (m_r.bitCnt == 4'd8)
              m_nxt.sda = 1'b1; // Released so the slave can ack, or to decline the read byte.
            else if (m_r.rdPass && m_r.byteNo == 2'd1) m_nxt.sda = 1'b1;
            else m_nxt.sda = txb[3'd7 - m_r.bitCnt[2:0]];
          end
          else if (m_r.phase == 2'd1) m_nxt.scl = 1'b1;
          else
          begin
            m_nxt.scl = 1'b0;
            m_nxt.phase = 2'd0;
            if (m_r.bitCnt == 4'd8)
            begin
              if (m_r.sdaSync[1] && !(m_r.rdPass && m_r.byteNo == 2'd1)) m_nxt.nack = 1'b1;
              if (m_r.rdPass && m_r.byteNo == 2'd1) m_nxt.rdat = m_r.shift;
              m_nxt.bitCnt = 4'd0;
              m_nxt.byteNo = m_r.byteNo + 2'd1;
              if (m_r.byteNo + 2'd1 == m_r.nBytes || m_nxt.nack)
              begin
                m_nxt.st = (m_r.rd && !m_r.rdPass && !m_nxt.nack) ? M_START : M_STOP;
                m_nxt.rdPass = m_r.rd;
              end
            end
            else
            begin
              m_nxt.shift = {m_r.shift[6:0], m_r.sdaSync[1]};
              m_nxt.bitCnt = m_r.bitCnt + 4'd1;
            end
          end
        end
        M_STOP:
        begin
          // Data low, clock up, then data rises under the high clock.
          m_nxt.phase = m_r.phase + 2'd1;
          if (m_r.phase == 2'd0) m_nxt.sda = 1'b0;
          else if (m_r.phase == 2'd1) m_nxt.scl = 1'b1;
          else
          begin
            m_nxt.sda = 1'b1;
            m_nxt.st = M_IDLE;
            m_nxt.phase = 2'd0;
          end
        end
        default: m_nxt.phase = 2'd0;
      endcase
    end
  end

  // Registers the whole state.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      m_r <= '0;
      m_r.sdaSync <= 2'b11;
      m_r.scl <= 1'b1;
      m_r.sda <= 1'b1;
      m_r.st <= M_IDLE;
    end
    else m_r <= m_nxt;
  end

  assign bus.sclMasterOe = m_r.scl;
  assign bus.sdaMasterOe = m_r.sda;
  assign prdata = m_r.prdata;
  assign pready = m_r.pready;
  assign pslverr = 1'b0;
endmodule
`default_nettype wire

// ---- tb/dbr_link_assertions.sv ----
// Checker of the two-wire link between the register master and the register slave.
`timescale 1ns/1ps
`default_nettype none
module dbr_link_assertions (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic scl,
  input wire logic sda,
  input wire logic sdaSlaveOe
);
  logic       sclQ;
  logic       sdaQ;
  logic       firstByte;
  logic       rdMode;
  logic [3:0] bitCnt;
  logic [7:0] shReg;
  logic [7:0] sinceRise;
  wire        sclRise   = scl & ~sclQ;
  wire        startSeen = sclQ & scl & sdaQ & ~sda;
  wire        stopSeen  = sclQ & scl & ~sdaQ & sda;

  // Tracks the bit position in a byte, the first byte after a start and the clock period.
  always_ff @(posedge clk_sys)
  begin
    sclQ      <= srst | scl;
    sdaQ      <= srst | sda;
    sinceRise <= srst ? 8'hFF : sclRise ? 8'h00 : sinceRise + {7'h00, sinceRise != 8'hFF};
    if (srst | startSeen)
    begin
      bitCnt    <= 4'h0;
      firstByte <= 1'h1;
      rdMode    <= 1'h0;
    end
    else if (sclRise && bitCnt == 4'h8)
    begin
      bitCnt    <= 4'h0;
      firstByte <= 1'h0;
      rdMode    <= firstByte ? shReg[0] : rdMode;
    end
    else if (sclRise)
    begin
      bitCnt <= bitCnt + 4'h1;
      shReg  <= {shReg[6:0], sda};
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  // Wire-level timing, framing and acknowledge checks.
  AST_SLAVE_EDGE: assert property ($changed(sdaSlaveOe) |-> !scl)
    else $error("slave data changed while clock high");
  AST_START_HOLD: assert property (startSeen |-> scl[*6])
    else $error("clock fell too soon after start");
  AST_STOP_RELEASE: assert property (stopSeen |-> sdaSlaveOe[*8])
    else $error("slave drives data after stop");
  AST_ADDR_ACK: assert property (sclRise && bitCnt == 4'h8 && firstByte && shReg[7:1] == dbr_pkg::SLAVE_ADDR |-> !sdaSlaveOe)
    else $error("own address not acknowledged");
  AST_WRITE_ACK: assert property (sclRise && bitCnt == 4'h8 && !firstByte && !rdMode |-> !sdaSlaveOe)
    else $error("received byte not acknowledged");
  AST_READ_RELEASE: assert property (sclRise && bitCnt == 4'h8 && !firstByte && rdMode |-> sdaSlaveOe)
    else $error("slave holds data in master acknowledge");
  AST_SCL_LOW: assert property ($fell(scl) |-> !scl[*8])
    else $error("clock low phase too short");
  AST_SCL_RATE: assert property (sclRise |-> sinceRise >= 8'h18)
    else $error("clock period too short");
endmodule
`default_nettype wire

// ---- tb/dbr_tb.sv ----
// Self-checking bench joining the register master and the register slave over the link.
`timescale 1ns/1ps
`default_nettype none
module dbr_tb;
  logic        clk_sys;
  logic        srst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [3:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic [7:0]  commonCfg;
  logic [7:0]  railOneCfg;
  logic [7:0]  railTwoCfg;
  logic        busBusy;
  logic [7:0]  golden [3];
  int          badCount  = 0;
  int          nCompared = 0;
  int          cycles    = 0;

  dbr_if busLink ();

  dbr_master u_dbr_master (.clk_sys(clk_sys), .srst(srst), .bus(busLink.host), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr());

  dbr_slave u_dbr_slave (.clk_sys(clk_sys), .srst(srst), .bus(busLink.device), .commonCfg(commonCfg),
    .railOneCfg(railOneCfg), .railTwoCfg(railTwoCfg), .busBusy(busBusy));

  dbr_link_assertions u_dbr_link_assertions (.clk_sys(clk_sys), .srst(srst), .scl(busLink.scl),
    .sda(busLink.sda), .sdaSlaveOe(busLink.sdaSlaveOe));

  // Makes the system clock.
  initial
  begin
    clk_sys = 1'h0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Cuts a hung run short.
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 80000)
    begin
      badCount++;
      endOfTest();
    end
  end

  // Prints the counts and the verdict, then stops.
  task automatic endOfTest();
    $display("compared %0d mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Compares one value with its expectation.
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] expected);
    nCompared++;
    if (seen !== expected)
    begin
      badCount++;
      $display("mismatch %s expected %h seen %h", what, expected, seen);
    end
  endtask

  // Runs one APB transfer and holds it until pready is sampled high.
  task automatic apb(input logic wr, input logic [3:0] addr, input logic [31:0] wdat, output logic [31:0] q);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdat;
    @(posedge clk_sys);
    penable <= 1'h1;
    do
      @(posedge clk_sys);
    while (pready !== 1'h1);
    q = prdata;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge clk_sys);
  endtask

  // Waits a bounded time for the slave's busy flag to reach a level.
  task automatic waitBusy(input logic lvl);
    int k;
    k = 0;
    while (busBusy !== lvl && k < 3000)
    begin
      @(posedge clk_sys);
      k++;
    end
  endtask

  // Orders one link transfer, optionally a second order while busy, and collects the result.
  task automatic xfer(input logic rd, input logic [7:0] idx, input logic [7:0] dat, input logic dup,
                      output logic [7:0] rb);
    logic [31:0] q;
    apb(1'h1, dbr_pkg::APB_CMD, {8'h00, dat, idx, 6'h00, rd, 1'h1}, q);
    if (dup)
      apb(1'h1, dbr_pkg::APB_CMD, {8'h00, ~dat, idx, 6'h00, rd, 1'h1}, q);
    waitBusy(1'h1);
    chk("busBusy", 32'(busBusy), 32'h1);
    do
      apb(1'h0, dbr_pkg::APB_STAT, 32'h0, q);
    while (q[dbr_pkg::STAT_BUSY_BIT] !== 1'h0);
    chk("nack", 32'(q[dbr_pkg::STAT_NACK_BIT]), 32'h0);
    waitBusy(1'h0);
    chk("busBusy", 32'(busBusy), 32'h0);
    apb(1'h0, dbr_pkg::APB_RDATA, 32'h0, q);
    rb = q[7:0];
  endtask

  // Compares the three register outputs with the expected contents.
  task automatic checkRegs();
    chk("commonCfg", 32'(commonCfg), 32'(golden[0]));
    chk("railOneCfg", 32'(railOneCfg), 32'(golden[1]));
    chk("railTwoCfg", 32'(railTwoCfg), 32'(golden[2]));
  endtask

  // Reset contents, idle bus and an unmapped APB read.
  task automatic testReset();
    logic [31:0] q;
    foreach (golden[i]) golden[i] = dbr_pkg::RESET_VALUE;
    checkRegs();
    chk("busBusy", 32'(busBusy), 32'h0);
    apb(1'h0, 4'hC, 32'h0, q);
    chk("unmapped", q, 32'h0);
  endtask

  // Writes and reads back every register with boundary codes and unused bits set.
  task automatic testWrites();
    logic [7:0] idx [5] = '{8'h00, 8'h01, 8'h01, 8'h02, 8'h02};
    logic [7:0] dat [5] = '{8'hA5, 8'hC5, 8'hD9, 8'h81, 8'hF0};
    logic [7:0] msk [5] = '{dbr_pkg::MASK_COMMON, dbr_pkg::MASK_RAIL_ONE, dbr_pkg::MASK_RAIL_ONE,
                            dbr_pkg::MASK_RAIL_TWO, dbr_pkg::MASK_RAIL_TWO};
    logic [7:0] rb;
    for (int i = 0; i < 5; i++)
    begin
      xfer(1'h0, idx[i], dat[i], 1'h0, rb);
      golden[idx[i][1:0]] = dat[i] & msk[i];
      checkRegs();
      xfer(1'h1, idx[i], 8'h00, 1'h0, rb);
      chk("readback", 32'(rb), 32'(golden[idx[i][1:0]]));
    end
  endtask

  // A write to an undefined index and an order issued while busy leave nothing changed.
  task automatic testOddCases();
    logic [7:0] rb;
    xfer(1'h0, 8'h03, 8'h5A, 1'h0, rb);
    checkRegs();
    xfer(1'h0, dbr_pkg::IDX_RAIL_TWO, 8'h12, 1'h1, rb);
    golden[2] = 8'h12;
    checkRegs();
  endtask

  // Main sequence.
  initial
  begin
    srst    = 1'h1;
    psel    = 1'h0;
    penable = 1'h0;
    pwrite  = 1'h0;
    paddr   = 4'h0;
    pwdata  = 32'h0;
    repeat (16) @(posedge clk_sys);
    srst <= 1'h0;
    @(posedge clk_sys);
    testReset();
    testWrites();
    testOddCases();
    endOfTest();
  end
endmodule
`default_nettype wire
